// ### dspc_params.svh
// Timing and width constants for the DSP core pipeline sequencing block
`ifndef DSPC_PARAMS_SVH
`define DSPC_PARAMS_SVH

// ----------------------------------------------------------------------
// Instruction cycle counts: base, condition-true and refill terms
// ----------------------------------------------------------------------
`define DSPC_JUMP_BASE_CYC   8'h04
`define DSPC_RET_BASE_CYC    8'h0a
`define DSPC_COND_TRUE_CYC   8'h02
`define DSPC_REFILL_CYC      8'h02

// ----------------------------------------------------------------------
// Program word counts
// ----------------------------------------------------------------------
`define DSPC_JUMP_WORDS      2'h2
`define DSPC_RET_WORDS       2'h1

// ----------------------------------------------------------------------
// Loop count register
// ----------------------------------------------------------------------
`define DSPC_LCNT_WIDTH      13
`define DSPC_LCNT_LIMIT      16'h2000
`define DSPC_LCNT_RESET      13'h0000

`endif

// ### dspc_pkg.sv
// Types shared by the DSP core pipeline sequencing block
package dspc_pkg;

  // Instruction class presented for sequencing
  typedef enum logic [1:0] {
    DSPC_OP_NONE   = 2'h0,
    DSPC_OP_JUMPCC = 2'h1,
    DSPC_OP_RETURN = 2'h2
  } dspc_op_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    DSPC_ST_IDLE   = 4'b0001,
    DSPC_ST_EXEC   = 4'b0010,
    DSPC_ST_FETCH1 = 4'b0100,
    DSPC_ST_FETCH2 = 4'b1000
  } dspc_state_t;

endpackage

// ### dspc_cnt_if.sv
// Carrier between the sequencer and its cycle counter
`timescale 1ns/1ps
`default_nettype none

interface dspc_cnt_if;
  logic       load;
  logic [7:0] load_val;
  logic       expired;

  modport ctl (output load, output load_val, input expired);
  modport cnt (input load, input load_val, output expired);
endinterface

`default_nettype wire

// ### dspc_cycle_cnt.sv
// Down counter that times each phase of an instruction sequence
`timescale 1ns/1ps
`default_nettype none

module dspc_cycle_cnt
  import dspc_pkg::*;
(
  // Clock and control
  input  wire logic  ref_clk,
  input  wire logic  reset,
  input  wire logic  clk_en,
  // Phase load and expiry
  dspc_cnt_if.cnt    cif
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // A load of N expires N cycles later, so a phase of N lasts N cycles
  always_comb begin
    cnt_d = cnt_q;
    if (cif.load) begin
      cnt_d = cif.load_val - 8'h01;
    end else if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= 8'h00;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  assign cif.expired = (cnt_q == 8'h00);

endmodule

`default_nettype wire

// ### dspc_pipe_seq.sv
// Pipeline timing sequencer, loop count register and parallel-move source of the DSP core
// Operation
// [RL1] Conditional jump: two words, four base cycles, plus two when condition true.
// [RL2] After a jump, two refill fetches each add the program wait cost.
// [RL3] Subroutine return: one word, ten base cycles plus return extra term.
// [RL4] Return extra equals twice the program wait cost for two refill fetches.
// [RL5] Program wait cost is zero internal, configured wait count external.
// [RL6] Software must not follow shift_to_leading_one with pointer_zero X access.
// [RL7] Bit-field operations must never target the hardware_stack register.
// [RL8] Loop count register is 13 bits; immediate loads must stay below 8192.
// [RL9] Loop counts never from stack, status or config registers; never zero.
// [RL10] No jump or branch at or into the last two loop addresses.
// [RL11] instruction_rerun never repeats program-memory or multiword instructions.
// [RL12] Unsigned conditions are valid only while unsigned_cond_enable is set.
// [RL13] pointer_three second X access always targets internal memory.
// [RL14] A moved pointer value is usable for addressing two instructions later.
// [RL15] After bit-field pointer change, next instruction must not use it.
// [RL16] Nested loops need two instructions after the loop register pop.
// [RL17] Parallel move from an ALU destination accumulator uses its old value.
// [RL18] Restricted sequences are not detected or interlocked by the core.
// [RL19] Returns add two X wait costs when the stack sits externally.
`timescale 1ns/1ps
`default_nettype none

// Port widths below use the shared constants, so they come in first
`include "dspc_params.svh"

module dspc_pipe_seq
  import dspc_pkg::*;
#(
  parameter int WAIT_W = 4,
  parameter int ACC_W  = 36
) (
  // Clock and control
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  input  wire logic                      clk_en,
  // Instruction issue
  input  wire logic                      issue_valid,
  input  wire dspc_op_t                  issue_op,
  input  wire logic                      cond_true,
  input  wire logic                      prog_external,
  input  wire logic                      xstack_external,
  // Wait-state configuration
  input  wire logic [WAIT_W-1:0]         prog_wait_states,
  input  wire logic [WAIT_W-1:0]         xmem_wait_states,
  // Sequencer status
  output logic                           busy_q,
  output logic                           done_q,
  output logic                           refill_fetch_q,
  output logic [7:0]                     total_cycles_q,
  output logic [1:0]                     prog_words_q,
  // Loop count register
  input  wire logic                      loop_count_wr,
  input  wire logic [15:0]               loop_count_wr_data,
  input  wire logic                      loop_count_dec,
  output logic [`DSPC_LCNT_WIDTH-1:0]    loop_count_reg_q,
  output logic                           loop_count_reject_q,
  // Condition qualification
  input  wire logic                      unsigned_cond_enable,
  input  wire logic                      unsigned_cond_req,
  output logic                           cond_legal_q,
  // Parallel move source
  input  wire logic                      alu_move_valid,
  input  wire logic [ACC_W-1:0]          acc_value,
  output logic [ACC_W-1:0]               move_data_q
);

  // ----------------------------------------------------------------------
  // Wait-cost helpers
  // ----------------------------------------------------------------------
  // [RL5] Wait cost by region
  function automatic logic [7:0] wait_cost(input logic ext, input logic [WAIT_W-1:0] ws);
    wait_cost = ext ? 8'(ws) : 8'h00;
  endfunction

  logic [7:0] program_fetch_wait;
  logic [7:0] ax;
  logic [7:0] fetch_wait_q;
  logic [7:0] fetch_wait_d;

  assign program_fetch_wait = wait_cost(prog_external, prog_wait_states);
  assign ax = wait_cost(xstack_external, xmem_wait_states);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  dspc_cnt_if cif ();

  dspc_cycle_cnt u_cnt (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .cif     (cif.cnt)
  );

  dspc_state_t state_q;
  dspc_state_t state_d;
  logic        busy_d;
  logic        done_d;
  logic        refill_d;
  logic [7:0]  total_d;
  logic [1:0]  words_d;
  logic [7:0]  base;

  // The exec phase excludes the two refill fetch slots, which run later
  always_comb begin
    state_d      = state_q;
    busy_d       = busy_q;
    done_d       = 1'b0;
    refill_d     = 1'b0;
    total_d      = total_cycles_q;
    words_d      = prog_words_q;
    fetch_wait_d = fetch_wait_q;
    base         = 8'h00;
    cif.load     = 1'b0;
    cif.load_val = 8'h00;
    case (state_q)
      DSPC_ST_IDLE: begin
        // [RL18] No interlock: issues while busy are ignored, not checked
        if (issue_valid && issue_op != DSPC_OP_NONE) begin
          if (issue_op == DSPC_OP_JUMPCC) begin
            // [RL1] Jump base and condition term
            base    = `DSPC_JUMP_BASE_CYC + (cond_true ? `DSPC_COND_TRUE_CYC : 8'h00);
            words_d = `DSPC_JUMP_WORDS;
          end else begin
            // [RL3] Return base, [RL19] stack fetches
            base    = `DSPC_RET_BASE_CYC + 8'({ax[6:0], 1'b0});
            words_d = `DSPC_RET_WORDS;
          end
          // [RL4] Two program wait costs on top of base
          total_d      = base + 8'({program_fetch_wait[6:0], 1'b0});
          fetch_wait_d = program_fetch_wait;
          cif.load     = 1'b1;
          cif.load_val = base - `DSPC_REFILL_CYC;
          busy_d       = 1'b1;
          state_d      = DSPC_ST_EXEC;
        end
      end
      DSPC_ST_EXEC: begin
        if (cif.expired) begin
          // [RL2] First refill fetch
          cif.load     = 1'b1;
          cif.load_val = 8'h01 + fetch_wait_q;
          refill_d     = 1'b1;
          state_d      = DSPC_ST_FETCH1;
        end
      end
      DSPC_ST_FETCH1: begin
        if (cif.expired) begin
          // [RL2] Second refill fetch
          cif.load     = 1'b1;
          cif.load_val = 8'h01 + fetch_wait_q;
          refill_d     = 1'b1;
          state_d      = DSPC_ST_FETCH2;
        end
      end
      DSPC_ST_FETCH2: begin
        if (cif.expired) begin
          busy_d  = 1'b0;
          done_d  = 1'b1;
          state_d = DSPC_ST_IDLE;
        end
      end
      default: begin
        busy_d  = 1'b0;
        state_d = DSPC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q        <= DSPC_ST_IDLE;
      busy_q         <= 1'b0;
      done_q         <= 1'b0;
      refill_fetch_q <= 1'b0;
      total_cycles_q <= 8'h00;
      prog_words_q   <= 2'h0;
      fetch_wait_q   <= 8'h00;
    end else if (clk_en) begin
      state_q        <= state_d;
      busy_q         <= busy_d;
      done_q         <= done_d;
      refill_fetch_q <= refill_d;
      total_cycles_q <= total_d;
      prog_words_q   <= words_d;
      fetch_wait_q   <= fetch_wait_d;
    end
  end

  // ----------------------------------------------------------------------
  // Loop count register and condition qualification
  // ----------------------------------------------------------------------
  logic [`DSPC_LCNT_WIDTH-1:0] loop_count_d;
  logic                        loop_count_rej_d;
  logic                        cond_legal_d;

  always_comb begin
    loop_count_d     = loop_count_reg_q;
    loop_count_rej_d = 1'b0;
    // [RL8] Only loads below the limit are taken; write beats decrement
    if (loop_count_wr) begin
      if (loop_count_wr_data < `DSPC_LCNT_LIMIT) begin
        loop_count_d = loop_count_wr_data[`DSPC_LCNT_WIDTH-1:0];
      end else begin
        loop_count_rej_d = 1'b1;
      end
    end else if (loop_count_dec && loop_count_reg_q != `DSPC_LCNT_RESET) begin
      loop_count_d = loop_count_reg_q - `DSPC_LCNT_WIDTH'(1);
    end
    // [RL12] Unsigned conditions gated by mode bit
    cond_legal_d = !unsigned_cond_req || unsigned_cond_enable;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      loop_count_reg_q    <= `DSPC_LCNT_RESET;
      loop_count_reject_q <= 1'b0;
      cond_legal_q        <= 1'b0;
    end else if (clk_en) begin
      loop_count_reg_q    <= loop_count_d;
      loop_count_reject_q <= loop_count_rej_d;
      cond_legal_q        <= cond_legal_d;
    end
  end

  // ----------------------------------------------------------------------
  // Parallel move source
  // ----------------------------------------------------------------------
  logic [ACC_W-1:0] move_d;

  // [RL17] Sample accumulator before the ALU result lands
  always_comb begin
    move_d = alu_move_valid ? acc_value : move_data_q;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      move_data_q <= '0;
    end else if (clk_en) begin
      move_data_q <= move_d;
    end
  end

endmodule

`default_nettype wire

// ### dspc_pipe_seq_asserts.sv
// Concurrent checks on the ports of the pipeline sequencing block
`timescale 1ns/1ps
`default_nettype none
`include "dspc_params.svh"
module dspc_pipe_seq_asserts
  import dspc_pkg::*;
#(parameter int WAIT_W = 4, parameter int ACC_W = 36) (
  // Clock and control
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Issue
  input wire logic issue_valid,
  input wire dspc_op_t issue_op,
  input wire logic cond_true,
  input wire logic prog_external,
  input wire logic xstack_external,
  input wire logic [WAIT_W-1:0] prog_wait_states,
  input wire logic [WAIT_W-1:0] xmem_wait_states,
  // Status
  input wire logic busy_q,
  input wire logic done_q,
  input wire logic refill_fetch_q,
  input wire logic [7:0] total_cycles_q,
  input wire logic [1:0] prog_words_q,
  // Loop count, condition and move
  input wire logic loop_count_wr,
  input wire logic [15:0] loop_count_wr_data,
  input wire logic loop_count_dec,
  input wire logic [`DSPC_LCNT_WIDTH-1:0] loop_count_reg_q,
  input wire logic loop_count_reject_q,
  input wire logic unsigned_cond_enable,
  input wire logic unsigned_cond_req,
  input wire logic cond_legal_q,
  input wire logic alu_move_valid,
  input wire logic [ACC_W-1:0] acc_value,
  input wire logic [ACC_W-1:0] move_data_q
);
  logic take;
  logic [7:0] program_fetch_wait, ax, busy_n_q, refill_n_q;
  assign take = clk_en && issue_valid && !busy_q;
  assign program_fetch_wait = prog_external ? 8'(prog_wait_states) : 8'h00;
  assign ax = xstack_external ? 8'(xmem_wait_states) : 8'h00;
  // Restart at each completion so back-to-back issues are measured apart
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_n_q <= 8'h00;
      refill_n_q <= 8'h00;
    end else if (clk_en) begin
      busy_n_q <= busy_q ? busy_n_q + 8'h01 : 8'h00;
      refill_n_q <= done_q ? 8'h00 : refill_n_q + 8'(refill_fetch_q);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_jump_cycles: assert property (
    take && issue_op == DSPC_OP_JUMPCC |=> total_cycles_q ==
    8'h04 + ($past(cond_true) ? 8'h02 : 8'h00) + 8'h02 * $past(program_fetch_wait))
    else $error("jump cycle count wrong");
  a_ret_cycles: assert property (
    take && issue_op == DSPC_OP_RETURN |=> total_cycles_q ==
    8'h0a + 8'h02 * $past(program_fetch_wait) + 8'h02 * $past(ax))
    else $error("return cycle count wrong");
  a_word_count: assert property (
    take && issue_op != DSPC_OP_NONE |=> prog_words_q ==
    (($past(issue_op) == DSPC_OP_JUMPCC) ? 2'h2 : 2'h1))
    else $error("program word count wrong");
  a_busy_length: assert property (
    done_q |-> busy_n_q == total_cycles_q && !busy_q)
    else $error("busy length differs from total");
  a_refill_pair: assert property (
    done_q |-> refill_n_q == 8'h02) else $error("refill fetch count not two");
  a_count_load: assert property (
    clk_en && loop_count_wr && loop_count_wr_data < 16'h2000 |=>
    loop_count_reg_q == $past(loop_count_wr_data[12:0])) else $error("loop count load wrong");
  a_count_reject: assert property (
    clk_en && loop_count_wr && loop_count_wr_data >= 16'h2000 |=>
    loop_count_reject_q && $stable(loop_count_reg_q)) else $error("wide load not refused");
  a_count_decrement: assert property (
    clk_en && !loop_count_wr && loop_count_dec && loop_count_reg_q != 13'h0000 |=>
    loop_count_reg_q == $past(loop_count_reg_q) - 13'h0001)
    else $error("loop count step wrong");
  a_idle_ignored: assert property (
    clk_en && !busy_q && !(issue_valid && issue_op != DSPC_OP_NONE) |=> !busy_q)
    else $error("sequencer started without a request");
  a_cond_gate: assert property (
    clk_en |=> cond_legal_q ==
    (!$past(unsigned_cond_req) || $past(unsigned_cond_enable)))
    else $error("unsigned condition gating wrong");
  a_move_old: assert property (
    clk_en && alu_move_valid |=> move_data_q == $past(acc_value))
    else $error("move source not old value");
endmodule
bind dspc_pipe_seq dspc_pipe_seq_asserts #(.WAIT_W(WAIT_W), .ACC_W(ACC_W)) u_chk (.*);
`default_nettype wire

// ### dspc_prog_mem_model.sv
// Program memory model holding a short instruction stream
`timescale 1ns/1ps
`default_nettype none
module dspc_prog_mem_model
  import dspc_pkg::*;
(
  // Fetch address
  input wire logic [2:0] pc,
  // Instruction and its memory placement
  output dspc_op_t issue_op,
  output logic cond_true,
  output logic prog_external,
  output logic xstack_external,
  output logic [3:0] prog_wait_states,
  output logic [3:0] xmem_wait_states
);
  logic [12:0] word;
  // Restriction free stream
  // Only jumps and returns are held, so no restricted sequence can arise
  always_comb begin
    case (pc)
      3'h0: word = 13'h0e40;
      3'h1: word = 13'h0840;
      3'h2: word = 13'h1040;
      3'h3: word = 13'h1323;
      3'h4: word = 13'h0c00;
      3'h5: word = 13'h110f;
      default: word = 13'h0000;
    endcase
  end
  assign issue_op = dspc_op_t'(word[12:11]);
  assign cond_true = word[10];
  assign prog_external = word[9];
  assign xstack_external = word[8];
  assign prog_wait_states = word[7:4];
  assign xmem_wait_states = word[3:0];
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the pipeline sequencing block
`timescale 1ns/1ps
`default_nettype none
`include "dspc_params.svh"
module tb;
  import dspc_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, issue_valid = 1'b0;
  logic loop_count_wr = 1'b0, loop_count_dec = 1'b0, unsigned_cond_enable = 1'b0;
  logic unsigned_cond_req = 1'b0, alu_move_valid = 1'b0;
  logic [15:0] loop_count_wr_data = 16'h0000;
  logic [35:0] acc_value = 36'h0_0000_0000;
  logic [2:0] pc = 3'h7;
  dspc_op_t issue_op;
  logic cond_true, prog_external, xstack_external, busy_q, done_q, refill_fetch_q;
  logic loop_count_reject_q, cond_legal_q;
  logic [3:0] prog_wait_states, xmem_wait_states;
  logic [7:0] total_cycles_q;
  logic [1:0] prog_words_q;
  logic [`DSPC_LCNT_WIDTH-1:0] loop_count_reg_q;
  logic [35:0] move_data_q;
  int errors = 0, num_checks = 0, cycles = 0;

  dspc_prog_mem_model u_mem (.*);
  dspc_pipe_seq uut (.*);

  initial forever #20 ref_clk = ~ref_clk;

  task automatic report_and_stop;
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [35:0] exp, input logic [35:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Stops the run as a failure once 2000 clock cycles have passed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      report_and_stop();
    end
  end

  // Issue from the current stream entry; next issue lands back to back
  task automatic run_op(output int nb, output int nr);
    nb = 0;
    nr = 0;
    issue_valid = 1'b1;
    @(negedge ref_clk);
    issue_valid = 1'b0;
    for (int k = 0; k < 100 && done_q !== 1'b1; k++) begin
      nb += int'(busy_q === 1'b1);
      nr += int'(refill_fetch_q === 1'b1);
      @(negedge ref_clk);
    end
    check("done", 1, done_q);
  endtask

  task automatic t_timing;
    int nb, nr, t;
    for (int i = 0; i < 6; i++) begin
      pc = i[2:0];
      run_op(nb, nr);
      // Entry still selected, so the stream fields have settled by now
      t = (issue_op == DSPC_OP_JUMPCC) ? 4 + 2 * cond_true
                                       : 10 + 2 * (xstack_external ? xmem_wait_states : 0);
      t += 2 * (prog_external ? prog_wait_states : 0);
      check("total", t, total_cycles_q);
      check("busy cycles", t, nb);
      check("refills", 2, nr);
      check("words", (i == 2 || i == 3 || i == 5) ? 1 : 2, prog_words_q);
    end
  endtask

  task automatic t_refuse;
    pc = 3'h1;
    issue_valid = 1'b1;
    @(negedge ref_clk);
    pc = 3'h3;
    repeat (3) @(negedge ref_clk);
    issue_valid = 1'b0;
    check("refused issue", 4, total_cycles_q);
    repeat (4) @(negedge ref_clk);
    // Valid with no instruction class is not a request
    pc = 3'h7;
    issue_valid = 1'b1;
    @(negedge ref_clk);
    check("none ignored", 0, busy_q);
    // Reset in mid-instruction abandons it
    pc = 3'h5;
    @(negedge ref_clk);
    issue_valid = 1'b0;
    reset = 1'b1;
    @(negedge ref_clk);
    reset = 1'b0;
    check("reset busy", 0, busy_q);
    check("reset total", 0, total_cycles_q);
  endtask

  task automatic t_loop_count;
    loop_count_wr = 1'b1;
    loop_count_wr_data = 16'h1fff;
    @(negedge ref_clk);
    check("count max", 36'h1fff, loop_count_reg_q);
    loop_count_wr_data = 16'h2000;
    @(negedge ref_clk);
    loop_count_wr = 1'b0;
    check("count reject", 1, loop_count_reject_q);
    check("count kept", 36'h1fff, loop_count_reg_q);
    loop_count_dec = 1'b1;
    clk_en = 1'b0;
    @(negedge ref_clk);
    check("count frozen", 36'h1fff, loop_count_reg_q);
    clk_en = 1'b1;
    @(negedge ref_clk);
    loop_count_dec = 1'b0;
    check("count dec", 36'h1ffe, loop_count_reg_q);
    check("reject pulse", 0, loop_count_reject_q);
  endtask

  task automatic t_cond;
    for (int i = 0; i < 4; i++) begin
      {unsigned_cond_enable, unsigned_cond_req} = i[1:0];
      @(negedge ref_clk);
      check("cond legal", !i[0] || i[1], cond_legal_q);
    end
  endtask

  task automatic t_move;
    acc_value = 36'h8_0000_0001;
    alu_move_valid = 1'b1;
    @(negedge ref_clk);
    acc_value = 36'h1_2345_6789;
    alu_move_valid = 1'b0;
    @(negedge ref_clk);
    check("move data", 36'h8_0000_0001, move_data_q);
  endtask

  initial begin
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    check("count reset", 36'h0, loop_count_reg_q);
    check("total reset", 36'h0, total_cycles_q);
    t_timing();
    t_refuse();
    t_loop_count();
    t_cond();
    t_move();
    report_and_stop();
  end
endmodule
`default_nettype wire
